/* File: hw/dmc_pkg.sv */
// Constants, field layout and shared functions of the device monitor configuration block
// ==========================================================================
// How it works
// - Bit 15 set keeps a checksum over addresses 40h to 59h; clear keeps none.
// - Bit 14 picks the 16-bit polynomial for frames and map: 0 CCITT, 1 ANSI.
// - Bit 13 set enables the serial clock edge counter.
// - Bit 12 set flags a timeout unless chip select rises within 2^14 oscillator periods of its fall.
// - After a timeout serial bits are ignored until chip select rises; the next fall starts afresh.
// - Bits 11:9 and 7:3 always read as zero.
// - Bit 8 gives the fault output level while a fault is present: 0 low, 1 high.
// - A fault is present while any unmasked upper status flag in bits 14:7 is set.
// - Pin 2 shows the fault only when its source select picks it, in the style of its format setting.
// - Bit 2 gives the lost-host level on detection, 0 low and 1 high, in the pin 0 format.
// - A watchdog times the gap between valid commands with a good checksum and flags overruns.
// - Window field 00 disables detection; 01, 10, 11 give 5120, 10240, 20480 oscillator periods.
// - Once set, the lost-host output stays active until the window field is written with 00.
package dmc_pkg;

    // ======================================================================
    // Register map
    localparam logic [6:0]  CFG_ADDR          = 7'h40;
    localparam logic [6:0]  SECTION1_FIRST    = 7'h40;
    localparam logic [6:0]  SECTION1_LAST     = 7'h59;
    localparam logic [15:0] CFG_RESET         = 16'h0000;
    localparam logic [15:0] CFG_WRITABLE_MASK = 16'hF107;

    // ======================================================================
    // Field positions
    localparam int BIT_SECTION1_EN  = 15;
    localparam int BIT_POLY_SELECT  = 14;
    localparam int BIT_SCLK_COUNT   = 13;
    localparam int BIT_TIMEOUT_EN   = 12;
    localparam int BIT_FAULT_OUTPUT_POLARITY    = 8;
    localparam int BIT_LOST_POL     = 2;
    localparam int WINDOW_MSB       = 1;
    localparam int WINDOW_LSB       = 0;
    localparam int FAULT_FLAG_MSB   = 14;
    localparam int FAULT_FLAG_LSB   = 7;

    // ======================================================================
    // Checksum
    localparam logic [15:0] POLY_CCITT = 16'h1021;
    localparam logic [15:0] POLY_ANSI  = 16'h8005;
    localparam logic [15:0] CRC_SEED   = 16'hFFFF;

    // ======================================================================
    // Timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int OSC_PERIOD_PS   = 122070;
    // Nearest whole cycle: the oscillator period is not a multiple of the clock
    localparam int OSC_DIV_CYCLES  = (OSC_PERIOD_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
    localparam int FRAME_TIMEOUT_OSC = 16384;
    localparam int WINDOW1_OSC     = 5120;
    localparam int WINDOW2_OSC     = 10240;
    localparam int WINDOW3_OSC     = 20480;
    localparam int LINK_WORD_BITS  = 24;

    // One 16-bit word into a running checksum, most significant bit first
    function automatic logic [15:0] dmc_crc16(input logic [15:0] acc,
                                              input logic [15:0] word,
                                              input logic [15:0] poly);
        logic [15:0] c;
        c = acc;
        for (int i = 15; i >= 0; i--) begin
            if (c[15] ^ word[i]) begin
                c = {c[14:0], 1'b0} ^ poly;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : dmc_crc16

    // Pin level and enable: push-pull drives always, open-drain only pulls low
    function automatic logic [1:0] dmc_pin_drive(input logic active,
                                                 input logic polarity,
                                                 input logic open_drain);
        logic level;
        level = active ? polarity : ~polarity;
        if (open_drain) begin
            return {1'b0, ~level};
        end
        return {level, 1'b1};
    endfunction : dmc_pin_drive

endpackage : dmc_pkg

/* File: hw/dmc_link.sv */
// Serial clock domain: edge counter and input shifter of the current frame
`timescale 1ns/1ps
module dmc_link #(
    parameter int WORD_BITS = dmc_pkg::LINK_WORD_BITS
) (
    input  wire logic                 i_sclk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_chip_select_n,
    input  wire logic                 i_serial_data_in,
    input  wire logic                 i_count_enable,
    input  wire logic                 i_discard,
    output logic      [15:0]          o_sclk_count,
    output logic      [WORD_BITS-1:0] o_frame_word
);

    typedef struct packed {
        logic                 en_meta;
        logic                 en_sync;
        logic                 dis_meta;
        logic                 dis_sync;
        logic [15:0]          edges;
        logic [15:0]          shown;
        logic [WORD_BITS-1:0] shift;
    } dmc_link_s;

    dmc_link_s s;
    dmc_link_s next_s;

    // ======================================================================
    // Next state
    always_comb begin
        next_s          = s;
        next_s.en_meta  = i_count_enable;
        next_s.en_sync  = s.en_meta;
        next_s.dis_meta = i_discard;
        next_s.dis_sync = s.dis_meta;
        next_s.edges    = s.edges + 16'h0001;
        // Edges are counted from the first one; the enable only gates what is shown
        next_s.shown    = s.en_sync ? next_s.edges : 16'h0000;
        if (!s.dis_sync) begin
            next_s.shift = {s.shift[WORD_BITS-2:0], i_serial_data_in};
        end
    end

    // ======================================================================
    // Registers: a high chip select ends the frame and clears everything
    always_ff @(posedge i_sclk or posedge i_sys_rst or posedge i_chip_select_n) begin
        if (i_sys_rst || i_chip_select_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_sclk_count = s.shown;
    assign o_frame_word = s.shift;

endmodule : dmc_link

/* File: hw/dmc_monitor.sv */
// Device monitor configuration register, frame timeout, lost-host watchdog and pin drive
`timescale 1ns/1ps
module dmc_monitor #(
    parameter int P_OSC_DIV       = dmc_pkg::OSC_DIV_CYCLES,
    parameter int P_FRAME_TIMEOUT = dmc_pkg::FRAME_TIMEOUT_OSC,
    parameter int P_WINDOW1       = dmc_pkg::WINDOW1_OSC,
    parameter int P_WINDOW2       = dmc_pkg::WINDOW2_OSC,
    parameter int P_WINDOW3       = dmc_pkg::WINDOW3_OSC,
    parameter int WORD_BITS       = dmc_pkg::LINK_WORD_BITS
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_sclk,
    input  wire logic                 i_chip_select_n,
    input  wire logic                 i_serial_data_in,
    input  wire logic                 i_reg_write,
    input  wire logic                 i_reg_read,
    input  wire logic [6:0]           i_reg_addr,
    input  wire logic [15:0]          i_reg_wdata,
    input  wire logic                 i_cmd_valid,
    input  wire logic                 i_cmd_crc_ok,
    input  wire logic [15:0]          i_status_msb,
    input  wire logic [15:0]          i_status_mask,
    input  wire logic                 i_pin2_source_select,
    input  wire logic                 i_pin2_output_format,
    input  wire logic                 i_pin0_direction,
    input  wire logic                 i_pin0_source_select,
    input  wire logic                 i_pin0_output_format,
    input  wire logic [15:0]          i_section1_rdata,
    output logic      [15:0]          o_reg_rdata,
    output logic                      o_reg_rvalid,
    output logic      [15:0]          o_crc_poly,
    output logic      [15:0]          o_regmap_crc,
    output logic                      o_regmap_crc_valid,
    output logic      [6:0]           o_section1_addr,
    output logic                      o_frame_timeout,
    output logic                      o_lost_host_output,
    output logic                      o_pin2_out,
    output logic                      o_pin2_oe,
    output logic                      o_pin0_out,
    output logic                      o_pin0_oe,
    output logic      [15:0]          o_sclk_count,
    output logic      [WORD_BITS-1:0] o_frame_word
);

    localparam logic [15:0] OSC_LAST     = 16'(P_OSC_DIV - 1);
    localparam logic [15:0] TIMEOUT_LAST = 16'(P_FRAME_TIMEOUT - 1);

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] osc_count;
        logic        cs_meta;
        logic        cs_sync;
        logic        cs_prev;
        logic        in_frame;
        logic [15:0] frame_timer;
        logic        discard;
        logic [15:0] wd_count;
        logic [1:0]  prev_window;
        logic        lost;
        logic [6:0]  crc_addr;
        logic [15:0] crc_acc;
        logic [15:0] crc_out;
        logic        crc_valid;
        logic [15:0] poly;
        logic [15:0] rdata;
        logic        rvalid;
        logic        pin2_out;
        logic        pin2_oe;
        logic        pin0_out;
        logic        pin0_oe;
    } dmc_state_s;

    dmc_state_s s;
    dmc_state_s next_s;

    // Last count of the selected window, zero when detection is off
    function automatic logic [15:0] window_last(input logic [1:0] sel);
        unique case (sel)
            2'b00: window_last = 16'h0000;
            2'b01: window_last = 16'(P_WINDOW1 - 1);
            2'b10: window_last = 16'(P_WINDOW2 - 1);
            2'b11: window_last = 16'(P_WINDOW3 - 1);
        endcase
    endfunction : window_last

    // ======================================================================
    // Next state
    always_comb begin
        logic        osc_tick;
        logic        cs_fall;
        logic        cs_rise;
        logic [1:0]  window;
        logic [15:0] word;
        logic [15:0] acc;
        logic        fault;
        logic [1:0]  drive;
        osc_tick = 1'b0;
        cs_fall  = 1'b0;
        cs_rise  = 1'b0;
        window   = 2'b00;
        word     = 16'h0000;
        acc      = 16'h0000;
        fault    = 1'b0;
        drive    = 2'b00;
        next_s   = s;

        // Register access; only the writable fields are stored
        if (i_reg_write && (i_reg_addr == dmc_pkg::CFG_ADDR)) begin
            next_s.cfg = i_reg_wdata & dmc_pkg::CFG_WRITABLE_MASK;
        end
        next_s.rvalid = i_reg_read;
        if (i_reg_read) begin
            next_s.rdata = (i_reg_addr == dmc_pkg::CFG_ADDR) ? s.cfg : 16'h0000;
        end
        window = s.cfg[dmc_pkg::WINDOW_MSB:dmc_pkg::WINDOW_LSB];

        // Oscillator period strobe derived from the system clock
        if (s.osc_count == OSC_LAST) begin
            next_s.osc_count = 16'h0000;
            osc_tick         = 1'b1;
        end else begin
            next_s.osc_count = s.osc_count + 16'h0001;
        end

        // Chip select is a pin, so it is synchronised before this block takes its edges
        next_s.cs_meta = i_chip_select_n;
        next_s.cs_sync = s.cs_meta;
        next_s.cs_prev = s.cs_sync;
        cs_fall        = s.cs_prev && !s.cs_sync;
        cs_rise        = !s.cs_prev && s.cs_sync;

        // ==================================================================
        // Frame timeout
        if (cs_fall) begin
            next_s.in_frame    = 1'b1;
            next_s.frame_timer = 16'h0000;
            next_s.discard     = 1'b0;
        end else if (cs_rise) begin
            next_s.in_frame = 1'b0;
            next_s.discard  = 1'b0;
        end else if (s.in_frame && s.cfg[dmc_pkg::BIT_TIMEOUT_EN] && osc_tick && !s.discard) begin
            if (s.frame_timer == TIMEOUT_LAST) begin
                next_s.discard = 1'b1;
            end else begin
                next_s.frame_timer = s.frame_timer + 16'h0001;
            end
        end

        // ==================================================================
        // Lost-host watchdog
        next_s.prev_window = window;
        if (window == 2'b00) begin
            next_s.wd_count = 16'h0000;
            next_s.lost     = 1'b0;
        end else if (s.prev_window == 2'b00) begin
            next_s.wd_count = 16'h0000;
        end else if (i_cmd_valid && i_cmd_crc_ok) begin
            next_s.wd_count = 16'h0000;
        end else if (osc_tick && !s.lost) begin
            if (s.wd_count >= window_last(window)) begin
                next_s.lost = 1'b1;
            end else begin
                next_s.wd_count = s.wd_count + 16'h0001;
            end
        end

        // ==================================================================
        // Register map checksum, one word per cycle over the section
        next_s.poly = s.cfg[dmc_pkg::BIT_POLY_SELECT] ? dmc_pkg::POLY_ANSI
                                                     : dmc_pkg::POLY_CCITT;
        if (!s.cfg[dmc_pkg::BIT_SECTION1_EN]) begin
            next_s.crc_addr  = dmc_pkg::SECTION1_FIRST;
            next_s.crc_acc   = dmc_pkg::CRC_SEED;
            next_s.crc_out   = 16'h0000;
            next_s.crc_valid = 1'b0;
        end else begin
            word = (s.crc_addr == dmc_pkg::CFG_ADDR) ? s.cfg : i_section1_rdata;
            acc  = dmc_pkg::dmc_crc16(s.crc_acc, word, s.poly);
            if (s.crc_addr == dmc_pkg::SECTION1_LAST) begin
                next_s.crc_out   = acc;
                next_s.crc_valid = 1'b1;
                next_s.crc_acc   = dmc_pkg::CRC_SEED;
                next_s.crc_addr  = dmc_pkg::SECTION1_FIRST;
            end else begin
                next_s.crc_acc  = acc;
                next_s.crc_addr = s.crc_addr + 7'h01;
            end
        end

        // ==================================================================
        // Pin drive
        fault = |(i_status_msb[dmc_pkg::FAULT_FLAG_MSB:dmc_pkg::FAULT_FLAG_LSB]
                  & ~i_status_mask[dmc_pkg::FAULT_FLAG_MSB:dmc_pkg::FAULT_FLAG_LSB]);
        drive = dmc_pkg::dmc_pin_drive(fault, s.cfg[dmc_pkg::BIT_FAULT_OUTPUT_POLARITY],
                                       i_pin2_output_format);
        if (i_pin2_source_select) begin
            {next_s.pin2_out, next_s.pin2_oe} = drive;
        end else begin
            {next_s.pin2_out, next_s.pin2_oe} = 2'b00;
        end
        drive = dmc_pkg::dmc_pin_drive(s.lost, s.cfg[dmc_pkg::BIT_LOST_POL],
                                       i_pin0_output_format);
        // Left undriven unless the host has set the pin up for it
        if (i_pin0_direction && i_pin0_source_select) begin
            {next_s.pin0_out, next_s.pin0_oe} = drive;
        end else begin
            {next_s.pin0_out, next_s.pin0_oe} = 2'b00;
        end
    end

    // ======================================================================
    // Registers
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s             <= '0;
            s.cfg         <= dmc_pkg::CFG_RESET;
            s.cs_meta     <= 1'b1;
            s.cs_sync     <= 1'b1;
            s.cs_prev     <= 1'b1;
            s.crc_addr    <= dmc_pkg::SECTION1_FIRST;
            s.crc_acc     <= dmc_pkg::CRC_SEED;
            s.poly        <= dmc_pkg::POLY_CCITT;
            s.pin2_oe     <= 1'b0;
            s.pin0_oe     <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ======================================================================
    // Serial clock side
    dmc_link #(
        .WORD_BITS        (WORD_BITS)
    ) u_link (
        .i_sclk           (i_sclk),
        .i_sys_rst        (i_sys_rst),
        .i_chip_select_n  (i_chip_select_n),
        .i_serial_data_in (i_serial_data_in),
        .i_count_enable   (s.cfg[dmc_pkg::BIT_SCLK_COUNT]),
        .i_discard        (s.discard),
        .o_sclk_count     (o_sclk_count),
        .o_frame_word     (o_frame_word)
    );

    assign o_reg_rdata        = s.rdata;
    assign o_reg_rvalid       = s.rvalid;
    assign o_crc_poly         = s.poly;
    assign o_regmap_crc       = s.crc_out;
    assign o_regmap_crc_valid = s.crc_valid;
    assign o_section1_addr    = s.crc_addr;
    assign o_frame_timeout    = s.discard;
    assign o_lost_host_output = s.lost;
    assign o_pin2_out         = s.pin2_out;
    assign o_pin2_oe          = s.pin2_oe;
    assign o_pin0_out         = s.pin0_out;
    assign o_pin0_oe          = s.pin0_oe;

endmodule : dmc_monitor

/* File: bench/dmc_monitor_props.sv */
// Port-level assertions for the monitor configuration block
`timescale 1ns/1ps
module dmc_monitor_props (
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic        i_reg_write,
    input wire logic        i_reg_read,
    input wire logic [6:0]  i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic        i_cmd_valid,
    input wire logic        i_cmd_crc_ok,
    input wire logic [15:0] i_status_msb,
    input wire logic [15:0] i_status_mask,
    input wire logic        i_pin2_source_select,
    input wire logic        i_pin2_output_format,
    input wire logic        i_pin0_direction,
    input wire logic        i_pin0_source_select,
    input wire logic        i_pin0_output_format,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic [15:0] o_crc_poly,
    input wire logic [15:0] o_regmap_crc,
    input wire logic        o_regmap_crc_valid,
    input wire logic        o_lost_host_output,
    input wire logic        o_pin2_out,
    input wire logic        o_pin2_oe,
    input wire logic        o_pin0_out,
    input wire logic        o_pin0_oe
);
    // ====
    // Shadow of the stored word
    logic [15:0] cfg_q;
    logic        up_q;
    logic        fault;
    logic [1:0]  exp_pin2;
    logic [1:0]  exp_pin0;
    function automatic logic [1:0] drive(input logic act, input logic pol, input logic od);
        logic lvl;
        lvl = act ? pol : ~pol;
        return od ? {1'b0, ~lvl} : {lvl, 1'b1};
    endfunction : drive
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_q <= 16'h0000;
            up_q  <= 1'b0;
        end else begin
            up_q <= 1'b1;
            if (i_reg_write && i_reg_addr == 7'h40) begin
                cfg_q <= i_reg_wdata & 16'hf107;
            end
        end
    end
    assign fault    = |(i_status_msb[14:7] & ~i_status_mask[14:7]);
    assign exp_pin2 = i_pin2_source_select ? drive(fault, cfg_q[8], i_pin2_output_format) : 2'b00;
    assign exp_pin0 = (i_pin0_direction && i_pin0_source_select) ?
        drive(o_lost_host_output, cfg_q[2], i_pin0_output_format) : 2'b00;
    // ====
    // Assertions
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    sequence s_lost_held;
        o_lost_host_output && cfg_q[1:0] != 2'b00;
    endsequence
    sequence s_good_cmd;
        i_cmd_valid && i_cmd_crc_ok && !o_lost_host_output;
    endsequence
    chk_read_data: assert property (i_reg_read |=> o_reg_rvalid && o_reg_rdata ==
        ($past(i_reg_addr) == 7'h40 ? $past(cfg_q) : 16'h0000)) else $error("read data wrong");
    chk_poly_select: assert property (o_crc_poly == ($past(cfg_q[14]) ? 16'h8005 : 16'h1021))
        else $error("polynomial wrong");
    chk_map_off: assert property (!cfg_q[15] |=> !o_regmap_crc_valid && o_regmap_crc == 0)
        else $error("checksum kept while off");
    chk_lost_hold: assert property (s_lost_held |=> o_lost_host_output)
        else $error("lost flag dropped");
    chk_lost_clear: assert property (cfg_q[1:0] == 2'b00 |=> !o_lost_host_output)
        else $error("lost flag while disabled");
    chk_cmd_restart: assert property (s_good_cmd |=> !o_lost_host_output [*8])
        else $error("lost flag soon after command");
    chk_fault_pin: assert property (up_q |-> {o_pin2_out, o_pin2_oe} == $past(exp_pin2))
        else $error("fault pin wrong");
    chk_fault_src: assert property (up_q && !$past(i_pin2_source_select) |-> !o_pin2_oe)
        else $error("fault pin driven when not selected");
    chk_lost_pin: assert property (up_q |-> {o_pin0_out, o_pin0_oe} == $past(exp_pin0))
        else $error("lost pin wrong");
endmodule : dmc_monitor_props

/* File: bench/dmc_host_model.sv */
// Behavioural host driving the serial frame pins
`timescale 1ns/1ps
module dmc_host_model (
    output logic o_sclk,
    output logic o_chip_select_n,
    output logic o_serial_data_in
);
    // ====
    // Clock stands low outside frames
    initial begin
        o_sclk           = 1'b0;
        o_chip_select_n  = 1'b1;
        o_serial_data_in = 1'b0;
    end
    task automatic start_frame();
        #13 o_chip_select_n = 1'b0;
        #40;
    endtask : start_frame
    task automatic shift(input logic [23:0] data, input int bits);
        for (int i = bits - 1; i >= 0; i--) begin
            o_serial_data_in = data[i];
            #40 o_sclk = 1'b1;
            #40 o_sclk = 1'b0;
        end
    endtask : shift
    // Unpulled data line shows the inverse once released
    task automatic end_frame();
        #40 o_chip_select_n = 1'b1;
        o_serial_data_in = ~o_serial_data_in;
    endtask : end_frame
endmodule : dmc_host_model

/* File: bench/device_monitor_config_test.sv */
// Self-checking bench for the device monitor configuration block
`timescale 1ns/1ps
module device_monitor_config_test;
    logic        i_clock = 1'b0, i_sys_rst = 1'b1, i_sclk, i_chip_select_n, i_serial_data_in;
    logic        i_reg_write = 1'b0, i_reg_read = 1'b0, i_cmd_valid = 1'b0, i_cmd_crc_ok = 1'b0;
    logic        i_pin2_source_select = 1'b1, i_pin2_output_format = 1'b0;
    logic        i_pin0_direction = 1'b1, i_pin0_source_select = 1'b1, i_pin0_output_format = 1'b0;
    logic [6:0]  i_reg_addr = 7'h40, o_section1_addr;
    logic [15:0] i_reg_wdata = 16'h0000, i_status_msb = 16'h0000, i_status_mask = 16'h0000;
    logic [15:0] i_section1_rdata, o_reg_rdata, o_crc_poly, o_regmap_crc, o_sclk_count;
    logic        o_reg_rvalid, o_regmap_crc_valid, o_frame_timeout, o_lost_host_output;
    logic        o_pin2_out, o_pin2_oe, o_pin0_out, o_pin0_oe;
    logic [23:0] o_frame_word;
    int          fails = 0, total_checks = 0, n;
    logic [31:0] lfsr = 32'h0000_1a55;
    logic [15:0] cfg_m = 16'h0000, acc;
    always #2 i_clock = ~i_clock;
    assign i_section1_rdata = {o_section1_addr, ~o_section1_addr, 2'b01};
    dmc_monitor #(.P_OSC_DIV(2), .P_FRAME_TIMEOUT(300), .P_WINDOW1(5), .P_WINDOW2(10),
        .P_WINDOW3(20)) dut_u (.i_clock, .i_sys_rst, .i_sclk, .i_chip_select_n,
        .i_serial_data_in, .i_reg_write, .i_reg_read, .i_reg_addr, .i_reg_wdata, .i_cmd_valid,
        .i_cmd_crc_ok, .i_status_msb, .i_status_mask, .i_pin2_source_select,
        .i_pin2_output_format, .i_pin0_direction, .i_pin0_source_select, .i_pin0_output_format,
        .i_section1_rdata, .o_reg_rdata, .o_reg_rvalid, .o_crc_poly, .o_regmap_crc,
        .o_regmap_crc_valid, .o_section1_addr, .o_frame_timeout, .o_lost_host_output,
        .o_pin2_out, .o_pin2_oe, .o_pin0_out, .o_pin0_oe, .o_sclk_count, .o_frame_word);
    dmc_host_model host_u (.o_sclk(i_sclk), .o_chip_select_n(i_chip_select_n),
        .o_serial_data_in(i_serial_data_in));
    // ====
    // Helpers
    function automatic logic [15:0] crc_step(input logic [15:0] a, input logic [15:0] w,
                                             input logic [15:0] p);
        for (int i = 15; i >= 0; i--) begin
            a = (a[15] ^ w[i]) ? ({a[14:0], 1'b0} ^ p) : {a[14:0], 1'b0};
        end
        return a;
    endfunction : crc_step
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_rand
    task automatic tick(input int k = 1);
        repeat (k) @(negedge i_clock);
    endtask : tick
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        i_reg_addr  = a;
        i_reg_wdata = d;
        i_reg_write = 1'b1;
        tick();
        i_reg_write = 1'b0;
        if (a == 7'h40) cfg_m = d & 16'hf107;
        tick();
    endtask : wr
    task automatic rd(input logic [6:0] a);
        i_reg_addr = a;
        i_reg_read = 1'b1;
        tick();
        i_reg_read = 1'b0;
        chk("read valid", 24'h1, {23'h0, o_reg_rvalid});
        chk("read data", {8'h0, (a == 7'h40) ? cfg_m : 16'h0000}, {8'h0, o_reg_rdata});
        tick();
    endtask : rd
    task automatic cmd(input logic ok);
        i_cmd_valid  = 1'b1;
        i_cmd_crc_ok = ok;
        tick();
        i_cmd_valid  = 1'b0;
        tick();
    endtask : cmd
    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        #100000;
        fails++;
        conclude();
    end
    // ====
    // Main sequence
    initial begin
        tick(3);
        i_sys_rst = 1'b0;
        rd(7'h40);
        wr(7'h40, 16'hffff);
        rd(7'h40);
        for (int k = 0; k < 24; k++) begin
            lfsr = next_rand(lfsr);
            {i_status_msb, i_status_mask} = lfsr;
            {i_pin2_source_select, i_pin2_output_format, i_pin0_output_format} = lfsr[20:18];
            wr(lfsr[25] ? 7'h40 : 7'h5a, lfsr[31:16] ^ lfsr[15:0]);
            rd(lfsr[24] ? 7'h40 : 7'h41);
        end
        for (int p = 0; p < 2; p++) begin
            wr(7'h40, p ? 16'hc000 : 16'h8000);
            tick(80);
            acc = 16'hffff;
            for (int a = 7'h40; a <= 7'h59; a++) begin
                acc = crc_step(acc, (a == 7'h40) ? cfg_m : {a[6:0], ~a[6:0], 2'b01},
                               p ? 16'h8005 : 16'h1021);
            end
            chk("checksum", {8'h0, acc}, {8'h0, o_regmap_crc});
            chk("polynomial", {8'h0, p ? 16'h8005 : 16'h1021}, {8'h0, o_crc_poly});
        end
        wr(7'h40, 16'h0000);
        chk("checksum valid", 24'h0, {23'h0, o_regmap_crc_valid});
        {i_pin0_direction, i_pin0_source_select, i_pin0_output_format} = 3'b110;
        for (int w = 1; w < 4; w++) begin
            wr(7'h40, 16'h0004 | w[15:0]);
            n = 0;
            while (o_lost_host_output !== 1'b1 && n < 200) begin
                tick();
                n++;
            end
            chk("lost delay", 24'h1, {23'h0, n >= 5 * 2 ** w - 3 && n <= 5 * 2 ** w + 5});
            tick(2);
            chk("pin0 active", 24'h3, {22'h0, o_pin0_out, o_pin0_oe});
            cmd(1'b1);
            chk("lost kept", 24'h1, {23'h0, o_lost_host_output});
            wr(7'h40, 16'h0004);
            chk("lost cleared", 24'h0, {23'h0, o_lost_host_output});
            tick();
            chk("pin0 idle", 24'h1, {22'h0, o_pin0_out, o_pin0_oe});
        end
        wr(7'h40, 16'h0002);
        for (int k = 0; k < 6; k++) begin
            tick(12);
            cmd(1'b1);
        end
        chk("lost while fed", 24'h0, {23'h0, o_lost_host_output});
        n = 0;
        while (o_lost_host_output !== 1'b1 && n < 200) begin
            cmd(1'b0);
            n += 2;
        end
        chk("lost after bad", 24'h1, {23'h0, n >= 16 && n <= 24});
        wr(7'h40, 16'h3000);
        host_u.start_frame();
        tick(580);
        chk("early timeout", 24'h0, {23'h0, o_frame_timeout});
        tick(25);
        chk("timeout", 24'h1, {23'h0, o_frame_timeout});
        host_u.shift(24'hff_ffff, 24);
        chk("ignored bits", 24'h0, {3'h0, o_frame_word[23:3]});
        host_u.end_frame();
        tick(8);
        chk("timeout cleared", 24'h0, {23'h0, o_frame_timeout});
        host_u.start_frame();
        host_u.shift(24'h5a_c396, 24);
        chk("frame word", 24'h5a_c396, o_frame_word);
        chk("edge count", 24'h18, {8'h0, o_sclk_count});
        host_u.end_frame();
        tick(8);
        wr(7'h40, 16'h1000);
        host_u.start_frame();
        host_u.shift(24'ha5, 8);
        chk("count off", 24'h0, {8'h0, o_sclk_count});
        host_u.end_frame();
        tick(8);
        conclude();
    end
endmodule : device_monitor_config_test
bind dmc_monitor dmc_monitor_props chk_u (.*);
